// ---- rtl/margin_pkg.sv ----
// margin_pkg: constants, types and register layout for the margining block.
// assumes one 40 MHz core clock and a PMBus front end that delivers decoded
// command words to the block.
package margin_pkg;

	localparam int N_CHAN = 12;
	localparam int N_PWM = 8;
	localparam int N_DAC = 4;
	localparam int CODE_W = 8;
	localparam int VOUT_W = 16;
	localparam int PAGE_W = 4;

	// command code of the margin loop configuration word
	localparam logic [7:0] CMD_MARGIN_LOOP_CONFIG = 8'hDF;

	// field positions inside margin_loop_config
	localparam int CFG_SLOPE_BIT = 15;
	localparam int CFG_OPEN_LOOP_BIT = 14;
	localparam int CFG_INIT_LSB = 0;
	localparam logic [15:0] CFG_RESET = 16'h0000;
	localparam logic [CODE_W-1:0] DAC_INIT_VALUE = 8'h00;
	localparam logic [CODE_W-1:0] CODE_ZERO = 8'h00;
	localparam logic [CODE_W-1:0] CODE_FULL = 8'hFF;
	localparam logic [CODE_W-1:0] CODE_STEP = 8'h01;

	// averaging: four samples, sum shifted right by two
	localparam logic [1:0] AVG_LAST = 2'h3;
	localparam int AVG_SHIFT = 2;
	// band of 1 percent: |avg - target| * 100 > target
	localparam logic [7:0] BAND_PERCENT = 8'h64;

	// timing
	localparam int CLK_HZ = 40_000_000;
	localparam int PWM_HZ = 312_500;
	localparam int PWM_PERIOD = CLK_HZ / PWM_HZ;
	localparam int PWM_CNT_W = $clog2(PWM_PERIOD);
	localparam int HOLDOFF_MS = 100;
	localparam int HOLDOFF_CYC = (CLK_HZ / 1000) * HOLDOFF_MS;

	typedef enum logic [1:0] {
		OP_OFF = 2'b00,
		OP_LOW = 2'b01,
		OP_HIGH = 2'b10
	} margin_op_t;

	typedef enum logic [1:0] {
		MG_IDLE = 2'b00,
		MG_WAIT_PG = 2'b01,
		MG_RUN = 2'b10
	} margin_state_t;

	typedef struct packed {
		logic slope;
		logic open_loop;
		logic [CODE_W-1:0] init_value;
	} margin_cfg_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [PAGE_W-1:0] page;
		logic [15:0] wdata;
	} pmbus_cmd_t;

	typedef struct packed {
		logic valid;
		logic [PAGE_W-1:0] chan;
		logic [VOUT_W-1:0] vout;
	} vout_sample_t;

endpackage

// ---- rtl/closed_loop_margining.sv ----
// closed_loop_margining: closed-loop margining of 12 supplies, pwm on 0-7,
// external current dac codes on 8-11, with the margin configuration word.
// assumes synchronous inputs, an adc that delivers averaged-path samples per
// channel, and a dac master outside that ships current_dac_code_o.
//
// Summary of operation
// RULE1 - polarity bit: 0 more dac current or duty lowers, 1 as specified raises; pwm channels ignore it, wider duty always lowers
// RULE2 - open-loop bit 1 holds the code at the initial value while margining
// RULE3 - configuration bits 13 to 8 always read back as zero
// RULE4 - pwm channels start margining from the 8-bit initial value
// RULE5 - in open loop the initial value drives pwm duty or dac level directly
// RULE6 - channels 8 to 11 drive external dac outputs 0 to 3
// RULE7 - margining starts on a margin state once all supplies are power good
// RULE8 - average four samples; outside 1 percent of target, step once
// RULE9 - polarity bit picks step direction so output moves toward target
// RULE10 - after margin off with faults ignored, hold off fault monitoring 100ms
// RULE11 - fault when first step already overshoots target in margin direction
// RULE12 - fault when code hits zero or full scale with target unreached
// RULE13 - on fault keep margining, set status margin bit, channel bit, alert
// RULE14 - dac link failure shows as fault when code reaches full scale
// RULE15 - dac channels get initial value zero automatically
// RULE16 - channels 0 to 7 use pwm outputs 0 to 7 at 312.5kHz
// RULE17 - pwm and dac outputs are high impedance when margining inactive
// RULE18 - pin used for another function suppresses margining on it
// RULE19 - step is one code count, saturating at zero and full scale
// RULE20 - code freezes inside the 1 percent band, resumes once outside
`timescale 1ns/1ps
`default_nettype none

module closed_loop_margining #(
	parameter int HOLDOFF_CYCLES = margin_pkg::HOLDOFF_CYC
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire margin_pkg::pmbus_cmd_t cmd_i,
	input wire logic [1:0] margin_op_i,
	input wire logic ignore_faults_i,
	input wire logic all_power_good_i,
	input wire margin_pkg::vout_sample_t sample_i,
	input wire logic [margin_pkg::N_CHAN-1:0][margin_pkg::VOUT_W-1:0]
		target_high_i,
	input wire logic [margin_pkg::N_CHAN-1:0][margin_pkg::VOUT_W-1:0]
		target_low_i,
	input wire logic [margin_pkg::N_PWM-1:0] pin_other_function_i,
	input wire logic alert_enable_i,
	input wire logic status_clear_i,
	output logic [15:0] rd_data_o,
	output logic rd_valid_o,
	output logic [margin_pkg::N_PWM-1:0] margin_pwm_out_o,
	output logic [margin_pkg::N_PWM-1:0] margin_pwm_oe_o,
	output logic [margin_pkg::N_DAC-1:0][margin_pkg::CODE_W-1:0]
		current_dac_code_o,
	output logic [margin_pkg::N_DAC-1:0] current_dac_oe_o,
	output logic status_margin_o,
	output logic [margin_pkg::N_CHAN-1:0] margin_fault_o,
	output logic alert_o,
	output logic fault_monitor_hold_o
);

	localparam int NC = margin_pkg::N_CHAN;
	localparam int NP = margin_pkg::N_PWM;
	localparam int CW = margin_pkg::CODE_W;
	localparam int VW = margin_pkg::VOUT_W;
	localparam int PCW = margin_pkg::PWM_CNT_W;
	localparam int PAGE_W_T = margin_pkg::PAGE_W;

	function automatic logic is_dac_chan(input int ch);
		return ch >= NP;
	endfunction

	margin_pkg::margin_cfg_t cfg [NC];
	margin_pkg::margin_state_t state;
	margin_pkg::margin_state_t next_state;
	logic [CW-1:0] code [NC];
	logic [VW+1:0] acc [NC];
	logic [1:0] nsamp [NC];
	logic [NC-1:0] first_chk;
	logic [NC-1:0] stepped_once;
	logic [NC-1:0] fault_evt;
	logic [NC-1:0] chan_active;
	logic [PCW-1:0] pwm_phase;
	logic [31:0] hold_cnt;
	logic ignored_while_run;

	// register access decode
	wire cfg_hit = cmd_i.valid && cmd_i.code == margin_pkg::CMD_MARGIN_LOOP_CONFIG
		&& 32'(cmd_i.page) < NC;
	wire cfg_wr = cfg_hit && cmd_i.write;
	wire cfg_rd = cmd_i.valid && !cmd_i.write;
	wire [PAGE_W_T-1:0] page_sel = cmd_i.page;
	margin_pkg::margin_cfg_t rd_cfg;
	logic [15:0] rd_fields;
	assign rd_cfg = cfg[page_sel];
	// fields land by their package positions; every other bit stays zero
	always_comb begin
		rd_fields = 16'h0000; // RULE3
		rd_fields[margin_pkg::CFG_SLOPE_BIT] = rd_cfg.slope;
		rd_fields[margin_pkg::CFG_OPEN_LOOP_BIT] = rd_cfg.open_loop;
		rd_fields[margin_pkg::CFG_INIT_LSB +: CW] = rd_cfg.init_value;
	end
	wire [15:0] rd_word = cfg_hit ? rd_fields : 16'h0000; // RULE3

	// sequencing of the margin session
	wire op_margin = margin_op_i == margin_pkg::OP_LOW
		|| margin_op_i == margin_pkg::OP_HIGH;
	wire op_high = margin_op_i == margin_pkg::OP_HIGH;
	wire run = state == margin_pkg::MG_RUN;
	wire leaving = state != margin_pkg::MG_IDLE && !op_margin;

	always_comb begin
		next_state = state;
		unique case (state)
			margin_pkg::MG_IDLE: begin
				if (op_margin) begin
					next_state = margin_pkg::MG_WAIT_PG; // RULE7
				end
			end
			margin_pkg::MG_WAIT_PG: begin
				if (!op_margin) begin
					next_state = margin_pkg::MG_IDLE;
				end else if (all_power_good_i) begin
					next_state = margin_pkg::MG_RUN; // RULE7
				end
			end
			margin_pkg::MG_RUN: begin
				if (!op_margin) begin
					next_state = margin_pkg::MG_IDLE;
				end
			end
			default: begin
				next_state = margin_pkg::MG_IDLE;
			end
		endcase
	end

	wire start = state == margin_pkg::MG_WAIT_PG
		&& next_state == margin_pkg::MG_RUN;

	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			state <= margin_pkg::MG_IDLE;
			rd_data_o <= 16'h0000;
			rd_valid_o <= 1'b0;
			pwm_phase <= '0;
		end else begin
			state <= next_state;
			rd_data_o <= cfg_rd ? rd_word : rd_data_o;
			rd_valid_o <= cfg_rd;
			pwm_phase <= pwm_phase + PCW'(1); // RULE16
		end
	end

	// fault monitoring holdoff after an ignore-all-faults session; the
	// length is a parameter so a bench can run a short window
	wire hold_load = leaving && (ignored_while_run || (run && ignore_faults_i));
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			ignored_while_run <= 1'b0;
			hold_cnt <= 32'h00000000;
			fault_monitor_hold_o <= 1'b0;
		end else begin
			if (run && ignore_faults_i) begin
				ignored_while_run <= 1'b1;
			end else if (leaving) begin
				ignored_while_run <= 1'b0;
			end
			if (hold_load) begin
				hold_cnt <= 32'(HOLDOFF_CYCLES); // RULE10
			end else if (hold_cnt != 32'h00000000) begin
				hold_cnt <= hold_cnt - 32'h00000001;
			end
			// hold_cnt still carries the load value one cycle later, hence > 1
			fault_monitor_hold_o <= hold_load || hold_cnt > 32'h00000001; // RULE10
		end
	end

	// per-channel loop
	genvar g;
	generate
		for (g = 0; g < NC; g++) begin : g_chan
			localparam logic [PAGE_W_T-1:0] PG = PAGE_W_T'(g);
			localparam bit DAC = is_dac_chan(g);
			wire blocked = DAC ? 1'b0 : pin_other_function_i[g % NP]; // RULE18
			wire my_sample = run && sample_i.valid && sample_i.chan == PG;
			wire [VW+1:0] sum = acc[g] + {2'b00, sample_i.vout};
			wire [VW-1:0] avg = sum[VW+1:margin_pkg::AVG_SHIFT]; // RULE8
			wire iter = my_sample && nsamp[g] == margin_pkg::AVG_LAST;
			wire [VW-1:0] tgt = op_high ? target_high_i[g] : target_low_i[g];
			wire above = avg > tgt;
			wire [VW-1:0] diff = above ? avg - tgt : tgt - avg;
			wire out_band = ({8'h00, diff} * {{VW{1'b0}},
				margin_pkg::BAND_PERCENT}) > {8'h00, tgt}; // RULE8
			// the slope bit is read literally: for pwm both settings make a
			// wider duty pull the output down
			wire inc_raises = DAC && cfg[g].slope; // RULE1
			wire inc = (!above) == inc_raises; // RULE9
			wire at_limit = inc ? code[g] == margin_pkg::CODE_FULL
				: code[g] == margin_pkg::CODE_ZERO;
			wire overshoot = first_chk[g] && out_band
				&& (op_high ? above : !above); // RULE11
			wire saturated = out_band && at_limit; // RULE12 RULE14
			wire closed = !cfg[g].open_loop;
			wire [CW-1:0] stepped = inc ? code[g] + margin_pkg::CODE_STEP
				: code[g] - margin_pkg::CODE_STEP; // RULE19
			assign chan_active[g] = run && !blocked;
			assign fault_evt[g] = iter && closed && chan_active[g]
				&& (overshoot || saturated);

			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					cfg[g].slope <=
						margin_pkg::CFG_RESET[margin_pkg::CFG_SLOPE_BIT];
					cfg[g].open_loop <=
						margin_pkg::CFG_RESET[margin_pkg::CFG_OPEN_LOOP_BIT];
					cfg[g].init_value <=
						margin_pkg::CFG_RESET[margin_pkg::CFG_INIT_LSB +: CW];
				end else if (cfg_wr && cmd_i.page == PG) begin
					cfg[g].slope <= cmd_i.wdata[margin_pkg::CFG_SLOPE_BIT];
					cfg[g].open_loop <= cmd_i.wdata[margin_pkg::CFG_OPEN_LOOP_BIT];
					cfg[g].init_value <= DAC ? margin_pkg::DAC_INIT_VALUE
						: cmd_i.wdata[margin_pkg::CFG_INIT_LSB +: CW]; // RULE15
				end
			end

			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					code[g] <= margin_pkg::CODE_ZERO;
					acc[g] <= '0;
					nsamp[g] <= 2'h0;
					first_chk[g] <= 1'b0;
					stepped_once[g] <= 1'b0;
				end else if (start || !run) begin
					code[g] <= cfg[g].init_value; // RULE4 RULE15
					stepped_once[g] <= 1'b0;
					acc[g] <= '0;
					nsamp[g] <= 2'h0;
					first_chk[g] <= 1'b0;
				end else if (!closed) begin
					code[g] <= cfg[g].init_value; // RULE2 RULE5
				end else if (my_sample) begin
					nsamp[g] <= nsamp[g] + 2'h1;
					acc[g] <= iter ? '0 : sum;
					if (iter) begin
						// inside the band the code simply stays put
						if (out_band && !at_limit) begin
							code[g] <= stepped; // RULE8 RULE19 RULE20
						end
						// a later return to the initial code must not re-arm
						// the overshoot check, so only the first step counts
						first_chk[g] <= out_band && !at_limit
							&& !stepped_once[g]; // RULE11
						stepped_once[g] <= stepped_once[g]
							|| (out_band && !at_limit);
					end
				end
			end
		end
	endgenerate

	// pin drivers: pwm compare and dac code, enables only while margining
	generate
		for (g = 0; g < NP; g++) begin : g_pwm
			// the phase steps by two codes, so one period spans the 8-bit code
			wire duty_on = {pwm_phase, 1'b0} < code[g];
			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					margin_pwm_out_o[g] <= 1'b0;
					margin_pwm_oe_o[g] <= 1'b0;
				end else begin
					margin_pwm_out_o[g] <= duty_on; // RULE16
					margin_pwm_oe_o[g] <= chan_active[g]; // RULE16 RULE17 RULE18
				end
			end
		end
		// a dead dac link is invisible here: it only shows as saturation
		for (g = 0; g < margin_pkg::N_DAC; g++) begin : g_dac
			always_ff @(posedge core_clk_i) begin
				if (!rstn_i) begin
					current_dac_code_o[g] <= margin_pkg::CODE_ZERO;
					current_dac_oe_o[g] <= 1'b0;
				end else begin
					current_dac_code_o[g] <= code[NP + g]; // RULE6
					current_dac_oe_o[g] <= chan_active[NP + g]; // RULE6 RULE17
				end
			end
		end
	endgenerate

	// status: set wins over clear, margining carries on regardless
	wire any_fault = |fault_evt;
	wire keep = !status_clear_i;
	always_ff @(posedge core_clk_i) begin
		if (!rstn_i) begin
			status_margin_o <= 1'b0;
			margin_fault_o <= '0;
			alert_o <= 1'b0;
		end else begin
			status_margin_o <= any_fault || (status_margin_o && keep); // RULE13
			margin_fault_o <= fault_evt | (margin_fault_o & {NC{keep}}); // RULE13
			alert_o <= (alert_enable_i && any_fault) || (alert_o && keep); // RULE13
		end
	end

endmodule // closed_loop_margining
`default_nettype wire

// ---- tb/closed_loop_margining_sva.sv ----
// closed_loop_margining_sva: port checks of the margining block.
// assumes binding into closed_loop_margining with its holdoff count.
`timescale 1ns/1ps
`default_nettype none
module closed_loop_margining_sva #(
	parameter int HOLDOFF_CYCLES = 20
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire margin_pkg::pmbus_cmd_t cmd_i,
	input wire logic [1:0] margin_op_i,
	input wire logic all_power_good_i,
	input wire logic [7:0] pin_other_function_i,
	input wire logic [15:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic [7:0] margin_pwm_oe_o,
	input wire logic [3:0][7:0] current_dac_code_o,
	input wire logic [3:0] current_dac_oe_o,
	input wire logic fault_monitor_hold_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	int hold_cnt;
	logic [7:0] c0;
	assign c0 = current_dac_code_o[0];
	always_ff @(posedge core_clk_i)
		hold_cnt <= (rstn_i && fault_monitor_hold_o) ? hold_cnt + 1 : 0;
	chk_read_answer: assert property (cmd_i.valid
		|=> rd_valid_o == !$past(cmd_i.write)) else $error("bad answer");
	chk_read_zero: assert property (rd_valid_o
		|-> rd_data_o[13:8] == 6'h00) else $error("reserved bits set");
	chk_idle_hiz: assert property ((margin_op_i == 2'b00)[*3]
		|-> {margin_pwm_oe_o, current_dac_oe_o} == 12'h000)
		else $error("driven while idle");
	chk_pin_blocked: assert property (8'h00 == (margin_pwm_oe_o
		& pin_other_function_i & $past(pin_other_function_i)))
		else $error("blocked pin driven");
	// wrap at either end would swing the supply across its whole range
	chk_dac_step: assert property (current_dac_oe_o[0]
		&& $past(current_dac_oe_o[0]) |-> c0 == $past(c0)
		|| (c0 == $past(c0) + 8'h01 && $past(c0) != 8'hFF)
		|| (c0 == $past(c0) - 8'h01 && $past(c0) != 8'h00))
		else $error("dac code jumped");
	chk_hold_cause: assert property ($rose(fault_monitor_hold_o)
		|-> margin_op_i == 2'b00) else $error("holdoff while margining");
	chk_hold_length: assert property ($fell(fault_monitor_hold_o)
		|-> hold_cnt == HOLDOFF_CYCLES) else $error("holdoff length");
	chk_start_pg: assert property ($rose(|{margin_pwm_oe_o,
		current_dac_oe_o}) |-> $past(all_power_good_i, 2))
		else $error("drive before power good");
endmodule // closed_loop_margining_sva
bind closed_loop_margining closed_loop_margining_sva #(
	.HOLDOFF_CYCLES(HOLDOFF_CYCLES)
) u_closed_loop_margining_sva (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cmd_i(cmd_i),
	.margin_op_i(margin_op_i), .all_power_good_i(all_power_good_i),
	.pin_other_function_i(pin_other_function_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .margin_pwm_oe_o(margin_pwm_oe_o),
	.current_dac_code_o(current_dac_code_o),
	.current_dac_oe_o(current_dac_oe_o),
	.fault_monitor_hold_o(fault_monitor_hold_o)
);
`default_nettype wire

// ---- tb/supply_feedback_model.sv ----
// supply_feedback_model: supply on dac output 0 seen by the adc.
// assumes channel 8, positive slope, one sample every GAP cycles.
`timescale 1ns/1ps
`default_nettype none
module supply_feedback_model #(
	parameter int GAP = 8,
	parameter int BASE = 1000,
	parameter int GAIN = 40
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] code_i,
	input wire logic oe_i,
	input wire logic dead_i,
	output margin_pkg::vout_sample_t sample_o
);
	int cnt, drive, vout;
	// a released or silent dac sources no current
	assign drive = (oe_i && !dead_i) ? int'(code_i) : 0;
	assign vout = BASE + drive * GAIN;
	initial sample_o = '0;
	always @(posedge clk_i) begin
		cnt <= (!rstn_i || cnt == GAP - 1) ? 0 : cnt + 1;
		sample_o <= '{rstn_i && cnt == GAP - 1, 4'h8, 16'(vout)};
	end
endmodule // supply_feedback_model
`default_nettype wire

// ---- tb/closed_loop_margining_tb.sv ----
// closed_loop_margining_tb: register and margining sequences.
// assumes the feedback model closes the loop on channel 8 only.
`timescale 1ns/1ps
`default_nettype none
module closed_loop_margining_tb;
	localparam int HOLD = 20;
	logic clk, rstn, pg, ign, alert_en, dead, clr;
	margin_pkg::pmbus_cmd_t cmd;
	margin_pkg::vout_sample_t smp;
	logic [1:0] op;
	logic [11:0][15:0] tgt_hi, tgt_lo;
	logic [7:0] pin_other, pwm_out, pwm_oe;
	logic [3:0][7:0] dac_code;
	logic [3:0] dac_oe;
	logic [15:0] rd_data;
	logic [11:0] fault;
	logic rd_valid, status, alert, hold;
	int n_mismatch = 0, compares = 0, cnt;
	closed_loop_margining #(.HOLDOFF_CYCLES(HOLD)) u_closed_loop_margining (
		.core_clk_i(clk), .rstn_i(rstn), .cmd_i(cmd), .margin_op_i(op),
		.ignore_faults_i(ign), .all_power_good_i(pg), .sample_i(smp),
		.target_high_i(tgt_hi), .target_low_i(tgt_lo),
		.pin_other_function_i(pin_other), .alert_enable_i(alert_en),
		.status_clear_i(clr), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.margin_pwm_out_o(pwm_out), .margin_pwm_oe_o(pwm_oe),
		.current_dac_code_o(dac_code), .current_dac_oe_o(dac_oe),
		.status_margin_o(status), .margin_fault_o(fault), .alert_o(alert),
		.fault_monitor_hold_o(hold));
	supply_feedback_model u_supply_feedback_model (.clk_i(clk),
		.rstn_i(rstn), .code_i(dac_code[0]), .oe_i(dac_oe[0]),
		.dead_i(dead), .sample_o(smp));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// valid drops after the taking edge, so calls may follow back to back
	task automatic access(input logic wr, input logic [3:0] page,
		input logic [7:0] code, input logic [15:0] wd);
		cmd = '{1'b1, wr, code, page, wd};
		tick();
		cmd.valid = 1'b0;
	endtask
	task automatic rd(input logic [7:0] code, input logic [3:0] page,
		input logic [15:0] exp);
		access(1'b0, page, code, 16'h0000);
		check({15'h0000, rd_valid}, 16'h0001);
		check(rd_data, exp);
		tick();
	endtask
	task automatic wr(input logic [3:0] page, input logic [15:0] wd);
		access(1'b1, page, 8'hDF, wd);
		tick();
	endtask
	// sel high waits for the channel 8 fault, low for a dac code
	task automatic wait_for(input logic sel, input logic [7:0] exp,
		input int bound);
		cnt = 0;
		while (!(sel ? fault[8] === 1'b1 : dac_code[0] === exp)) begin
			tick();
			cnt++;
			if (cnt >= bound) begin
				n_mismatch++;
				tally_and_finish();
			end
		end
	endtask
	initial begin
		{rstn, pg, dead, clr, pin_other, op, tgt_hi, tgt_lo} = '0;
		cmd = '0;
		{ign, alert_en} = 2'b11;
		tgt_hi[8] = 16'h0708;
		tgt_lo[8] = 16'h03E8;
		tick(10);
		rstn = 1'b1;
		rd(8'hDF, 4'h5, 16'h0000);
		wr(4'h3, 16'hFFFF);
		rd(8'hDF, 4'h3, 16'hC0FF);
		wr(4'h9, 16'h8055);
		rd(8'hDF, 4'h9, 16'h8000);
		rd(8'hE0, 4'h0, 16'h0000);
		wr(4'h8, 16'h8000);
		op = 2'b10;
		tick(10);
		check({12'h000, dac_oe}, 16'h0000);
		pg = 1'b1;
		wait_for(1'b0, 8'h14, 3000);
		tick(200);
		check({8'h00, dac_code[0]}, 16'h0014);
		check({3'h0, dac_oe[0], fault}, 16'h1000);
		op = 2'b00;
		cnt = 0;
		repeat (60) begin
			tick();
			if (hold === 1'b1)
				cnt++;
		end
		check(16'(cnt), 16'h0014);
		check({pwm_oe, 4'h0, dac_oe}, 16'h0000);
		wr(4'h0, 16'h4040);
		op = 2'b01;
		tick(8);
		check({15'h0000, pwm_oe[0]}, 16'h0001);
		cnt = 0;
		repeat (128) begin
			tick();
			if (pwm_out[0] === 1'b1)
				cnt++;
		end
		check(16'(cnt), 16'h0020);
		pin_other[0] = 1'b1;
		tick(3);
		check({15'h0000, pwm_oe[0]}, 16'h0000);
		op = 2'b00;
		tick(40);
		tgt_hi[8] = 16'h03FC;
		op = 2'b10;
		wait_for(1'b1, 8'h00, 400);
		check({8'h00, dac_code[0]}, 16'h0001);
		op = 2'b00;
		clr = 1'b1;
		tick(2);
		clr = 1'b0;
		check({13'h0000, status, alert, fault[8]}, 16'h0000);
		tick(40);
		tgt_hi[8] = 16'h0708;
		{ign, dead} = 2'b01;
		op = 2'b10;
		wait_for(1'b1, 8'h00, 20000);
		check({8'h00, dac_code[0]}, 16'h00FF);
		check({13'h0000, status, alert, dac_oe[0]}, 16'h0007);
		tally_and_finish();
	end
endmodule // closed_loop_margining_tb
`default_nettype wire
